// *** rtl/dbsc_match.sv ***
/*
 * Breakpoint address comparator.
 * Assumes address and enable come from the same clock domain.
 */
`timescale 1ns/1ps
module dbsc_match #(
	parameter int ADDR_W = 16
) (
	input wire logic mclk_in,
	input wire logic rst_b_in,
	input wire logic enable_in,
	input wire logic addr_valid_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [ADDR_W-1:0] match_in,
	output logic hit_out
);
	// ****************************************
	// Compare
	// ****************************************
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			hit_out <= 1'b0;
		end else begin
			hit_out <= enable_in && addr_valid_in && (addr_in == match_in); // RULE1
		end
	end
endmodule

// *** rtl/dbsc_pkg.sv ***
/*
 * Shared constants and carrier types for the debug status/control and
 * hardware breakpoint block. Assumes a serial front end that delivers
 * whole decoded commands with their data.
 */
package dbsc_pkg;
	// Serial command codes
	localparam logic [7:0] CMD_READ_STATUS = 8'hE4;
	localparam logic [7:0] CMD_WRITE_CONTROL = 8'hC4;
	localparam logic [7:0] CMD_MATCH_READ = 8'hE2;
	localparam logic [7:0] CMD_MATCH_WRITE = 8'hC2;
	localparam logic [7:0] CMD_HALT = 8'h90;

	// Status/control bit positions
	localparam int BIT_DEBUG_PERMIT = 7;
	localparam int BIT_HALT_ACTIVE = 6;
	localparam int BIT_BKPT_ENABLE = 5;
	localparam int BIT_FORCE_TAG = 4;
	localparam int BIT_CLOCK_SELECT = 3;
	localparam int BIT_WAIT_STOP = 2;
	localparam int BIT_WS_FAILURE = 1;
	localparam int BIT_DV_FAILURE = 0;

	// Reset values
	localparam logic [7:0] SCR_NORMAL_RESET = 8'h00;
	localparam logic [7:0] SCR_HALT_RESET = 8'hC8;
	localparam logic [15:0] MATCH_RESET = 16'h0000;
	// Bits that the write-control command may change
	localparam logic [7:0] SCR_WRITE_MASK = 8'hB8;

	// Decoded serial command with its write data
	typedef struct packed {
		logic valid;
		logic [7:0] code;
		logic [15:0] data;
	} dbsc_cmd_t;

	// Read answer to the serial front end
	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} dbsc_rsp_t;

	// CPU side status observed by the block
	typedef struct packed {
		logic addr_valid;
		logic [15:0] addr;
		logic opcode_fetch;
		logic insn_boundary;
		logic queue_end_tagged;
		logic wait_stop;
		logic wait_stop_entry;
		logic slow_access_busy;
		logic mem_cmd_done;
	} dbsc_cpu_t;
endpackage

// *** rtl/dbsc_top.sv ***
/*
 * Debug status/control register, breakpoint match register and halt control.
 * Assumes a serial front end passes decoded commands on the same clock, and
 * that CPU status inputs are synchronous to mclk_in.
 */
// What this block does
// RULE1 - Compare CPU address against match register
// RULE2 - Forced mode halts at next instruction boundary
// RULE3 - Tagged mode marks opcode, halts at queue end
// RULE4 - Enable bit clear blocks all breakpoints
// RULE5 - Select bit: one forced, zero tagged
// RULE6 - Registers only reachable by serial commands
// RULE7 - Permit bit unwritable while halted
// RULE8 - Status bits are read-only
// RULE9 - Clock select bit always read/write, default zero
// RULE10 - Host sets or clears permit while not halted; normal reset clears it
// RULE11 - Halt-active bit shows halted state
// RULE12 - Wait/stop bit shows wait, stop, or woken-halt
// RULE13 - Halt command wakes CPU into halt
// RULE14 - Most commands fail during wait or stop
// RULE15 - Host confirms halt-active after forcing halt
// RULE16 - Wait/stop failure flags failed memory command
// RULE17 - Host recovers failures by halting and retrying
// RULE18 - Data-valid failure flags unfinished slow access
// RULE19 - Status read E4, control write C4
// RULE20 - Match read E2, match write C2
// RULE21 - Halt command 90 only when permitted
// RULE22 - Reset in halt loads permit, active, clock
// RULE23 - Writes to status positions are discarded
`timescale 1ns/1ps
module dbsc_top #(
	parameter bit HAS_SLOW_MEMORY = 1'b0
) (
	input wire logic mclk_in,
	input wire logic rst_b_in,
	input wire logic reset_in_halt_in,
	input wire dbsc_pkg::dbsc_cmd_t cmd_in,
	input wire dbsc_pkg::dbsc_cpu_t cpu_in,
	input wire logic resume_in,
	output dbsc_pkg::dbsc_rsp_t rsp_out,
	output logic halt_req_out,
	output logic wake_req_out,
	output logic cmd_blocked_out,
	output logic comm_clock_select_out
);
	// ****************************************
	// Registers
	// ****************************************
	logic debug_permit;
	logic halt_active;
	logic breakpoint_enable;
	logic force_tag_select;
	logic comm_clock_select;
	logic wait_stop_status;
	logic wait_stop_failure;
	logic data_valid_failure;
	logic woke_from_wait;
	logic [15:0] debug_match_address;
	logic reset_taken_in_halt;
	logic hit;
	logic tag_pending;
	logic force_pending;
	logic [7:0] status_byte;
	logic is_write_ctrl;
	logic is_match_write;
	logic is_halt_cmd;
	logic is_read;
	logic halt_event;
	logic force_now;

	assign status_byte = {debug_permit, halt_active, breakpoint_enable, force_tag_select,
		comm_clock_select, wait_stop_status, wait_stop_failure, data_valid_failure};
	// Only serial commands reach the registers; there is no CPU path
	assign is_write_ctrl = cmd_in.valid && (cmd_in.code == dbsc_pkg::CMD_WRITE_CONTROL); // RULE19 RULE6
	assign is_match_write = cmd_in.valid && (cmd_in.code == dbsc_pkg::CMD_MATCH_WRITE); // RULE20 RULE6
	assign is_halt_cmd = cmd_in.valid && (cmd_in.code == dbsc_pkg::CMD_HALT);
	assign is_read = cmd_in.valid &&
		((cmd_in.code == dbsc_pkg::CMD_READ_STATUS) || (cmd_in.code == dbsc_pkg::CMD_MATCH_READ));
	// Fresh hit counts too, so the next boundary is never missed
	assign force_now = force_pending || (hit && force_tag_select && breakpoint_enable);
	assign halt_event = !halt_active && debug_permit &&
		(is_halt_cmd || (force_now && cpu_in.insn_boundary) || (tag_pending && cpu_in.queue_end_tagged));

	// ****************************************
	// Reset flavour, caught after release
	// ****************************************
	logic rst_seen;
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rst_seen <= 1'b0;
			reset_taken_in_halt <= 1'b0;
		end else begin
			rst_seen <= 1'b1;
			if (!rst_seen) begin
				reset_taken_in_halt <= reset_in_halt_in;
			end else begin
				reset_taken_in_halt <= 1'b0;
			end
		end
	end

	// ****************************************
	// Breakpoint comparator
	// ****************************************
	dbsc_match #(
		.ADDR_W(16)
	) u_match (
		.mclk_in(mclk_in),
		.rst_b_in(rst_b_in),
		.enable_in(breakpoint_enable),
		.addr_valid_in(cpu_in.addr_valid),
		.addr_in(cpu_in.addr),
		.match_in(debug_match_address),
		.hit_out(hit)
	);

	logic fetch_d;
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			fetch_d <= 1'b0;
		end else begin
			fetch_d <= cpu_in.opcode_fetch;
		end
	end

	// ****************************************
	// Forced breakpoint request
	// ****************************************
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			force_pending <= 1'b0;
		end else if (!breakpoint_enable || halt_active) begin
			force_pending <= 1'b0; // RULE4
		end else if (hit && force_tag_select) begin
			force_pending <= 1'b1; // RULE2 RULE5
		end else if (cpu_in.insn_boundary) begin
			force_pending <= 1'b0;
		end
	end

	// ****************************************
	// Tag marking
	// ****************************************
	// Held until the marked opcode leaves the queue; a flushed queue keeps it armed
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			tag_pending <= 1'b0;
		end else if (!breakpoint_enable || halt_active) begin
			tag_pending <= 1'b0; // RULE4
		end else if (hit && !force_tag_select && fetch_d) begin
			tag_pending <= 1'b1; // RULE3 RULE5
		end else if (cpu_in.queue_end_tagged) begin
			tag_pending <= 1'b0;
		end
	end

	// ****************************************
	// Debug permit
	// ****************************************
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			debug_permit <= 1'b0;
		end else if (reset_taken_in_halt) begin
			debug_permit <= 1'b1; // RULE22
		end else if (is_write_ctrl && !halt_active) begin
			debug_permit <= cmd_in.data[dbsc_pkg::BIT_DEBUG_PERMIT]; // RULE7 RULE10
		end
	end

	// ****************************************
	// Control bits
	// ****************************************
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			breakpoint_enable <= 1'b0;
			force_tag_select <= 1'b0;
		end else if (reset_taken_in_halt) begin
			breakpoint_enable <= 1'b0; // RULE22
			force_tag_select <= 1'b0;
		end else if (is_write_ctrl) begin
			breakpoint_enable <= cmd_in.data[dbsc_pkg::BIT_BKPT_ENABLE]; // RULE4
			force_tag_select <= cmd_in.data[dbsc_pkg::BIT_FORCE_TAG]; // RULE5
		end
	end

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			comm_clock_select <= 1'b0;
		end else if (reset_taken_in_halt) begin
			comm_clock_select <= 1'b1; // RULE22
		end else if (is_write_ctrl) begin
			comm_clock_select <= cmd_in.data[dbsc_pkg::BIT_CLOCK_SELECT]; // RULE9 RULE23
		end
	end

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			debug_match_address <= dbsc_pkg::MATCH_RESET;
		end else if (is_match_write) begin
			debug_match_address <= cmd_in.data; // RULE20
		end
	end

	// ****************************************
	// Halt state and wait/stop status
	// ****************************************
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			halt_active <= 1'b0;
		end else if (reset_taken_in_halt) begin
			halt_active <= 1'b1; // RULE22
		end else if (halt_event) begin
			halt_active <= 1'b1; // RULE11 RULE21 RULE2 RULE3
		end else if (halt_active && resume_in) begin
			halt_active <= 1'b0; // RULE11
		end
	end

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			woke_from_wait <= 1'b0;
		end else if (reset_taken_in_halt) begin
			woke_from_wait <= 1'b0;
		end else if (halt_event) begin
			woke_from_wait <= is_halt_cmd && cpu_in.wait_stop; // RULE13 RULE12
		end else if (halt_active && resume_in) begin
			woke_from_wait <= 1'b0;
		end
	end

	// ****************************************
	// Wait/stop status bit
	// ****************************************
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wait_stop_status <= 1'b0;
		end else begin
			wait_stop_status <= (cpu_in.wait_stop && !halt_active) ||
				(halt_active && woke_from_wait) || (halt_event && is_halt_cmd && cpu_in.wait_stop); // RULE12 RULE8
		end
	end

	// ****************************************
	// Failure flags, set wins over clear
	// ****************************************
	logic ws_fail_set;
	logic dv_fail_set;
	assign ws_fail_set = cpu_in.mem_cmd_done && (cpu_in.wait_stop || cpu_in.wait_stop_entry);
	assign dv_fail_set = HAS_SLOW_MEMORY && cpu_in.mem_cmd_done && cpu_in.slow_access_busy;

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wait_stop_failure <= 1'b0;
		end else if (ws_fail_set) begin
			wait_stop_failure <= 1'b1; // RULE16 RULE8
		end else if (cpu_in.mem_cmd_done || reset_taken_in_halt) begin
			wait_stop_failure <= 1'b0;
		end
	end

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			data_valid_failure <= 1'b0;
		end else if (dv_fail_set) begin
			data_valid_failure <= 1'b1; // RULE18 RULE8
		end else if (cpu_in.mem_cmd_done || reset_taken_in_halt) begin
			data_valid_failure <= 1'b0;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rsp_out <= '0;
		end else begin
			rsp_out.valid <= is_read;
			if (cmd_in.code == dbsc_pkg::CMD_READ_STATUS) begin
				rsp_out.data <= {8'h00, status_byte}; // RULE19
			end else begin
				rsp_out.data <= debug_match_address; // RULE20
			end
		end
	end

	always_ff @(posedge mclk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			halt_req_out <= 1'b0;
			wake_req_out <= 1'b0;
			cmd_blocked_out <= 1'b0;
			comm_clock_select_out <= 1'b0;
		end else begin
			halt_req_out <= halt_event || (halt_active && !resume_in);
			wake_req_out <= halt_event && is_halt_cmd && cpu_in.wait_stop; // RULE13
			cmd_blocked_out <= cpu_in.wait_stop && !halt_active; // RULE14
			comm_clock_select_out <= comm_clock_select; // RULE9
		end
	end
endmodule

// *** tb/dbsc_host.sv ***
/* Debug host model issuing decoded serial commands. Assumes falling-edge drive. */
`timescale 1ns/1ps
module dbsc_host (
	input wire logic mclk_in,
	output dbsc_pkg::dbsc_cmd_t cmd_out
);
	initial cmd_out = '0;
	// One cycle per command, released fields scrambled
	task automatic send(input logic [7:0] code, input logic [15:0] data);
		@(negedge mclk_in);
		cmd_out = {1'b1, code, data};
		@(negedge mclk_in);
		cmd_out = {1'b0, ~code, ~data};
	endtask
endmodule

// *** tb/dbsc_properties.sv ***
/* Port checker for dbsc_top. Assumes the bind at the foot and one clock domain. */
`timescale 1ns/1ps
module dbsc_properties (
	input wire logic mclk_in,
	input wire logic rst_b_in,
	input wire logic reset_in_halt_in,
	input wire dbsc_pkg::dbsc_cmd_t cmd_in,
	input wire dbsc_pkg::dbsc_cpu_t cpu_in,
	input wire logic resume_in,
	input wire dbsc_pkg::dbsc_rsp_t rsp_out,
	input wire logic halt_req_out,
	input wire logic wake_req_out,
	input wire logic cmd_blocked_out,
	input wire logic comm_clock_select_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_b_in);
	status_read_a: assert property (cmd_in.valid && cmd_in.code == 8'hE4
		|=> rsp_out.valid && rsp_out.data[15:8] == 8'h00 && !rsp_out.data[0]) else $error("bad status answer");
	rsp_cause_a: assert property (rsp_out.valid
		|-> $past(cmd_in.valid && (cmd_in.code == 8'hE4 || cmd_in.code == 8'hE2))) else $error("stray answer");
	clock_sel_a: assert property (cmd_in.valid && cmd_in.code == 8'hC4
		##1 !(cmd_in.valid && cmd_in.code == 8'hC4)
		|=> comm_clock_select_out == $past(cmd_in.data[3], 2)) else $error("clock select not written");
	halt_shown_a: assert property (rsp_out.valid && $past(cmd_in.code) == 8'hE4
		|-> rsp_out.data[6] == $past(halt_req_out)) else $error("halt bit disagrees");
	wake_cause_a: assert property (wake_req_out
		|-> $past(cmd_in.valid && cmd_in.code == 8'h90 && cpu_in.wait_stop)) else $error("stray wake");
	blocked_cause_a: assert property ($rose(cmd_blocked_out) |-> $past(cpu_in.wait_stop))
		else $error("stray block");
	halt_cause_a: assert property ($rose(halt_req_out) |-> $past(cmd_in.valid && cmd_in.code == 8'h90)
		|| $past(cpu_in.insn_boundary) || $past(cpu_in.queue_end_tagged) || $past(reset_in_halt_in)
		|| $past(reset_in_halt_in, 2) || $past(reset_in_halt_in, 3)) else $error("halt without cause");
	halt_hold_a: assert property (halt_req_out && !resume_in |=> halt_req_out)
		else $error("halt dropped");
endmodule
bind dbsc_top dbsc_properties chk_u (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .reset_in_halt_in(reset_in_halt_in),
	.cmd_in(cmd_in), .cpu_in(cpu_in), .resume_in(resume_in), .rsp_out(rsp_out), .halt_req_out(halt_req_out),
	.wake_req_out(wake_req_out), .cmd_blocked_out(cmd_blocked_out), .comm_clock_select_out(comm_clock_select_out));

// *** tb/dbsc_top_bench.sv ***
/* Scenario bench for dbsc_top via the host model. Assumes dbsc_properties is bound. */
`timescale 1ns/1ps
module dbsc_top_bench;
	logic mclk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic reset_in_halt_in = 1'b0;
	logic resume_in = 1'b0;
	dbsc_pkg::dbsc_cpu_t cpu = '0;
	dbsc_pkg::dbsc_cmd_t cmd;
	dbsc_pkg::dbsc_rsp_t rsp;
	logic halt, wake, blk, csel;
	int n_mismatch = 0;
	int total_checks = 0;
	int cycles = 0;
	dbsc_host host_u (.mclk_in(mclk_in), .cmd_out(cmd));
	dbsc_top dut_u (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .reset_in_halt_in(reset_in_halt_in), .cmd_in(cmd),
		.cpu_in(cpu), .resume_in(resume_in), .rsp_out(rsp), .halt_req_out(halt), .wake_req_out(wake),
		.cmd_blocked_out(blk), .comm_clock_select_out(csel));
	initial forever #20 mclk_in = ~mclk_in;
	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			final_report();
		end
	end
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
		total_checks++;
		if (e !== g) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk_in);
	endtask
	task automatic rd(input logic [7:0] c, input logic [15:0] e, input string nm);
		host_u.send(c, 16'h0000);
		// Answer stands between the rising edges around this falling edge
		chk(nm, {1'b1, e}, rsp);
	endtask
	task automatic leave_halt();
		@(negedge mclk_in);
		resume_in = 1'b1;
		@(negedge mclk_in);
		resume_in = 1'b0;
		cyc(2);
	endtask
	task automatic t_reset();
		rd(8'hE4, 16'h0000, "status");
		rd(8'hE2, 16'h0000, "match");
		chk("clksel", 17'h0, {16'h0, csel});
		host_u.send(8'hC4, 16'h00FF);
		rd(8'hE4, 16'h00B8, "written");
		chk("clksel", 17'h1, {16'h0, csel});
		host_u.send(8'hC4, 16'h0000);
		rd(8'hE4, 16'h0000, "cleared");
		$display("test reset/control done");
	endtask
	task automatic t_halt();
		host_u.send(8'h90, 16'h0000);
		cyc(2);
		chk("refused", 17'h0, {16'h0, halt});
		host_u.send(8'hC4, 16'h0080);
		host_u.send(8'h90, 16'h0000);
		chk("no wake", 17'h0, {16'h0, wake});
		cyc(2);
		chk("halted", 17'h1, {16'h0, halt});
		rd(8'hE4, 16'h00C0, "halt st");
		host_u.send(8'hC4, 16'h0008);
		rd(8'hE4, 16'h00C8, "permit");
		leave_halt();
		rd(8'hE4, 16'h0088, "resumed");
		$display("test halt done");
	endtask
	task automatic t_bkpt();
		logic [7:0] ctl [4] = '{8'hB0, 8'h90, 8'hA0, 8'h80};
		host_u.send(8'hC2, 16'h1234);
		rd(8'hE2, 16'h1234, "match");
		for (int i = 0; i < 4; i++) begin
			host_u.send(8'hC4, {8'h00, ctl[i]});
			@(negedge mclk_in);
			cpu.addr_valid = 1'b1;
			cpu.addr = 16'h1234;
			cpu.opcode_fetch = !ctl[i][4];
			@(negedge mclk_in);
			cpu = '0;
			cyc(1);
			cpu.insn_boundary = ctl[i][4];
			cpu.queue_end_tagged = !ctl[i][4];
			@(negedge mclk_in);
			cpu = '0;
			cyc(1);
			chk("bkpt", {16'h0, ctl[i][5]}, {16'h0, halt});
			if (halt === 1'b1)
				leave_halt();
		end
		$display("test breakpoint done");
	endtask
	task automatic t_wait();
		host_u.send(8'hC4, 16'h0080);
		@(negedge mclk_in);
		cpu.wait_stop = 1'b1;
		cyc(2);
		chk("blocked", 17'h1, {16'h0, blk});
		rd(8'hE4, 16'h0084, "wait st");
		host_u.send(8'h90, 16'h0000);
		chk("wake", 17'h1, {16'h0, wake});
		cpu.wait_stop = 1'b0;
		cyc(2);
		rd(8'hE4, 16'h00C4, "woken");
		leave_halt();
		$display("test wait done");
	endtask
	task automatic t_fail();
		@(negedge mclk_in);
		cpu.mem_cmd_done = 1'b1;
		cpu.wait_stop_entry = 1'b1;
		cpu.slow_access_busy = 1'b1;
		@(negedge mclk_in);
		cpu = '0;
		rd(8'hE4, 16'h0082, "ws fail");
		@(negedge mclk_in);
		cpu.mem_cmd_done = 1'b1;
		@(negedge mclk_in);
		cpu = '0;
		rd(8'hE4, 16'h0080, "fail clr");
		$display("test failure flags done");
	endtask
	task automatic t_strap();
		@(negedge mclk_in);
		rst_b_in = 1'b0;
		reset_in_halt_in = 1'b1;
		cyc(2);
		rst_b_in = 1'b1;
		cyc(3);
		reset_in_halt_in = 1'b0;
		rd(8'hE4, 16'h00C8, "strap");
		chk("clksel", 17'h1, {16'h0, csel});
		$display("test halt reset done");
	endtask
	initial begin
		cyc(10);
		rst_b_in = 1'b1;
		cyc(2);
		t_reset();
		t_halt();
		t_bkpt();
		t_wait();
		t_fail();
		t_strap();
		final_report();
	end
endmodule
